// ==== hw/code_format_pkg.sv ====
// Contract
// - Output coding is chosen by top-bit and lower-bits flip selects together.
// - Both low gives offset binary; top-bit alone gives two's complement.
// - Both high gives inverted offset binary, zeros at top, ones at bottom.
// - Lower-bits alone gives inverted two's complement.
// - Over-range flag rises only above top reference sense level.
// - Over-range leaves data bits at the full-scale code of the coding.
// - Each sample strobe rising edge starts one conversion and its result.
package code_format_pkg;
   localparam int RESULT_WIDTH = 10;
   localparam logic [RESULT_WIDTH-1:0] FULL_SCALE_CODE = 10'h3FF;
   localparam logic [RESULT_WIDTH-1:0] ZERO_CODE       = 10'h000;
   localparam logic [RESULT_WIDTH-1:0] LOWER_MASK      = 10'h1FF;
   localparam logic [RESULT_WIDTH-1:0] TOP_BIT_MASK    = 10'h200;
   localparam int MSB_POS = RESULT_WIDTH - 1;
   localparam int SYNC_STAGES = 2;
endpackage : code_format_pkg

// ==== hw/code_transform.sv ====
`timescale 1ns/1ps
`default_nettype none
module code_transform
   import code_format_pkg::*;
(
   // Offset-binary input
   input  wire logic [RESULT_WIDTH-1:0] offset_code,
   // Coding selects
   input  wire logic                    top_bit_flip_select,
   input  wire logic                    lower_bits_flip_select,
   // Coded output
   output logic      [RESULT_WIDTH-1:0] coded
);
   always_comb begin
      coded = offset_code;
      if (top_bit_flip_select) begin
         coded[MSB_POS] = ~offset_code[MSB_POS];
      end
      if (lower_bits_flip_select) begin
         coded = coded ^ LOWER_MASK;
      end
   end
endmodule : code_transform
`default_nettype wire

// ==== hw/adc_output_code_formatter.sv ====
`timescale 1ns/1ps
`default_nettype none
module adc_output_code_formatter
   import code_format_pkg::*;
(
   // Clock, reset and enable
   input  wire logic                    clock,
   input  wire logic                    rst_b,
   input  wire logic                    clk_en,
   // Sample strobe and comparator result
   input  wire logic                    sample_strobe,
   input  wire logic [RESULT_WIDTH-1:0] comparator_code,
   input  wire logic                    above_top_reference_sense,
   // Coding straps
   input  wire logic                    top_bit_flip_select,
   input  wire logic                    lower_bits_flip_select,
   // Result
   output logic      [RESULT_WIDTH-1:0] conversion_result,
   output logic                         over_range,
   output logic                         result_valid
);
   // Every outside input but clk_en and rst_b goes through two flops; data and strobe share the delay.
   logic [SYNC_STAGES-1:0] strobe_sync_q;
   logic [SYNC_STAGES-1:0] over_sync_q;
   logic [SYNC_STAGES-1:0] top_sel_sync_q;
   logic [SYNC_STAGES-1:0] low_sel_sync_q;
   logic [RESULT_WIDTH-1:0] code_meta_q;
   logic [RESULT_WIDTH-1:0] code_sync_q;
   logic                    strobe_prev_q;
   logic                    strobe_rise;
   logic [RESULT_WIDTH-1:0] offset_code;
   logic [RESULT_WIDTH-1:0] coded;

   // The strobe and the over-range sense share one pipe depth, so the flag
   // lines up with the strobe edge that reports it.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         strobe_sync_q <= '0;
         over_sync_q   <= '0;
      end else if (clk_en) begin
         strobe_sync_q <= {strobe_sync_q[0], sample_strobe};
         over_sync_q   <= {over_sync_q[0], above_top_reference_sense};
      end
   end

   // Straps are meant to be static; a board that moves them anyway only
   // changes the coding of later results, never a result already taken.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         top_sel_sync_q <= '0;
         low_sel_sync_q <= '0;
      end else if (clk_en) begin
         top_sel_sync_q <= {top_sel_sync_q[0], top_bit_flip_select};
         low_sel_sync_q <= {low_sel_sync_q[0], lower_bits_flip_select};
      end
   end

   // The word has no handshake of its own: it must sit still for two clocks
   // before the strobe, so it leaves this pipe together with the strobe edge.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         code_meta_q <= ZERO_CODE;
         code_sync_q <= ZERO_CODE;
      end else if (clk_en) begin
         code_meta_q <= comparator_code;
         code_sync_q <= code_meta_q;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         strobe_prev_q <= 1'b0;
      end else if (clk_en) begin
         strobe_prev_q <= strobe_sync_q[1];
      end
   end

   assign strobe_rise = strobe_sync_q[1] & ~strobe_prev_q;

   // Over range forces the full-scale offset code; data is otherwise untouched.
   assign offset_code = over_sync_q[1] ? FULL_SCALE_CODE : code_sync_q;

   code_transform code_transform_inst (
      .offset_code            (offset_code),
      .top_bit_flip_select    (top_sel_sync_q[1]),
      .lower_bits_flip_select (low_sel_sync_q[1]),
      .coded                  (coded)
   );

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         conversion_result <= ZERO_CODE;
      end else if (clk_en && strobe_rise) begin
         conversion_result <= coded;
      end
   end

   // The flag has its own register, so it can never feed back into the data bits.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         over_range <= 1'b0;
      end else if (clk_en && strobe_rise) begin
         over_range <= over_sync_q[1];
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         result_valid <= 1'b0;
      end else if (clk_en) begin
         result_valid <= strobe_rise;
      end
   end

   a_offset_binary: assert property (@(posedge clock) disable iff (!rst_b)
      (clk_en && strobe_rise && !top_sel_sync_q[1] && !low_sel_sync_q[1])
      |=> conversion_result == $past(offset_code))
      else $error("offset binary coding wrong");

   a_twos_comp: assert property (@(posedge clock) disable iff (!rst_b)
      (clk_en && strobe_rise && top_sel_sync_q[1] && !low_sel_sync_q[1] && over_sync_q[1])
      |=> conversion_result == (FULL_SCALE_CODE ^ TOP_BIT_MASK))
      else $error("two's complement full scale wrong");

   a_inv_binary: assert property (@(posedge clock) disable iff (!rst_b)
      (clk_en && strobe_rise && top_sel_sync_q[1] && low_sel_sync_q[1])
      |=> conversion_result == ~$past(offset_code))
      else $error("inverted binary coding wrong");

   a_inv_twos: assert property (@(posedge clock) disable iff (!rst_b)
      (clk_en && strobe_rise && !top_sel_sync_q[1] && low_sel_sync_q[1] && over_sync_q[1])
      |=> conversion_result == (FULL_SCALE_CODE ^ LOWER_MASK))
      else $error("inverted two's complement full scale wrong");

   a_flag_cause: assert property (@(posedge clock) disable iff (!rst_b)
      (clk_en && strobe_rise) |=> over_range == $past(over_sync_q[1]))
      else $error("over range flag mismatch");

   a_flag_data: assert property (@(posedge clock) disable iff (!rst_b)
      (clk_en && strobe_rise && over_sync_q[1] && !top_sel_sync_q[1] && !low_sel_sync_q[1])
      |=> conversion_result == FULL_SCALE_CODE)
      else $error("over range data not full scale");

   a_hold_between: assert property (@(posedge clock) disable iff (!rst_b)
      !(clk_en && strobe_rise) |=> $stable(conversion_result) && $stable(over_range))
      else $error("result changed without strobe");

   a_valid_pulse: assert property (@(posedge clock) disable iff (!rst_b)
      (clk_en && strobe_rise) |=> result_valid)
      else $error("valid pulse wrong");

   a_valid_single: assert property (@(posedge clock) disable iff (!rst_b)
      (clk_en && result_valid) |=> !result_valid)
      else $error("valid pulse longer than one enabled cycle");

   a_msb_flip: assert property (@(posedge clock) disable iff (!rst_b)
      (clk_en && strobe_rise)
      |=> conversion_result[MSB_POS] == ($past(offset_code[MSB_POS]) ^ $past(top_sel_sync_q[1])))
      else $error("top bit flip wrong");

   a_twos_general: assert property (@(posedge clock) disable iff (!rst_b)
      (clk_en && strobe_rise && top_sel_sync_q[1] && !low_sel_sync_q[1])
      |=> conversion_result == ($past(offset_code) ^ TOP_BIT_MASK))
      else $error("two's complement coding wrong");

   a_inv_twos_general: assert property (@(posedge clock) disable iff (!rst_b)
      (clk_en && strobe_rise && !top_sel_sync_q[1] && low_sel_sync_q[1])
      |=> conversion_result == ($past(offset_code) ^ LOWER_MASK))
      else $error("inverted two's complement coding wrong");

   a_inv_binary_top: assert property (@(posedge clock) disable iff (!rst_b)
      (clk_en && strobe_rise && top_sel_sync_q[1] && low_sel_sync_q[1] && over_sync_q[1])
      |=> conversion_result == ZERO_CODE)
      else $error("inverted binary full scale wrong");

   a_lsb_flip: assert property (@(posedge clock) disable iff (!rst_b)
      (clk_en && strobe_rise)
      |=> conversion_result[MSB_POS-1:0] == ($past(offset_code[MSB_POS-1:0])
          ^ ($past(low_sel_sync_q[1]) ? LOWER_MASK[MSB_POS-1:0] : ZERO_CODE[MSB_POS-1:0])))
      else $error("lower bits flip wrong");

   a_flag_in_range: assert property (@(posedge clock) disable iff (!rst_b)
      (clk_en && strobe_rise && !over_sync_q[1]) |=> !over_range)
      else $error("over range flag raised in range");

   a_flag_raised: assert property (@(posedge clock) disable iff (!rst_b)
      (clk_en && strobe_rise && over_sync_q[1]) |=> over_range)
      else $error("over range flag not raised");

   a_flag_source: assert property (@(posedge clock) disable iff (!rst_b)
      $rose(over_range) |-> $past(clk_en && strobe_rise && over_sync_q[1]))
      else $error("over range flag rose without cause");

   a_data_source: assert property (@(posedge clock) disable iff (!rst_b)
      $changed(conversion_result) |-> $past(clk_en && strobe_rise))
      else $error("result moved without a strobe edge");

   a_valid_quiet: assert property (@(posedge clock) disable iff (!rst_b)
      (clk_en && !strobe_rise) |=> !result_valid)
      else $error("valid raised without a strobe edge");

   a_freeze_outputs: assert property (@(posedge clock) disable iff (!rst_b)
      !clk_en |=> $stable(conversion_result) && $stable(over_range) && $stable(result_valid))
      else $error("outputs moved while disabled");

   a_freeze_sync: assert property (@(posedge clock) disable iff (!rst_b)
      !clk_en |=> $stable(strobe_sync_q) && $stable(strobe_prev_q) && $stable(code_sync_q))
      else $error("input pipe moved while disabled");

   a_rise_single: assert property (@(posedge clock) disable iff (!rst_b)
      (clk_en && strobe_rise) |=> !strobe_rise)
      else $error("strobe edge seen twice");
endmodule : adc_output_code_formatter
`default_nettype wire

// ==== tb/capture_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module capture_model
   import code_format_pkg::*;
(
   // Clock and reset
   input  wire logic                    clock,
   input  wire logic                    rst_b,
   // Formatter outputs
   input  wire logic                    result_valid,
   input  wire logic [RESULT_WIDTH-1:0] conversion_result,
   input  wire logic                    over_range,
   // Latched word
   output logic      [RESULT_WIDTH-1:0] captured_code,
   output logic                         captured_flag
);
   // Latches only on the valid pulse, so a stale word is never taken twice.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         captured_code <= ZERO_CODE;
         captured_flag <= 1'b0;
      end else if (result_valid) begin
         captured_code <= conversion_result;
         captured_flag <= over_range;
      end
   end
endmodule : capture_model
`default_nettype wire

// ==== tb/adc_output_code_formatter_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module adc_output_code_formatter_test
   import code_format_pkg::*;
();
   logic                    clock = 1'b0;
   logic                    rst_b = 1'b0;
   logic                    strobe = 1'b0;
   logic                    above = 1'b0;
   logic                    top = 1'b0;
   logic                    lower = 1'b0;
   logic                    enable = 1'b1;
   logic [RESULT_WIDTH-1:0] code = ZERO_CODE;
   logic [RESULT_WIDTH-1:0] result;
   logic [RESULT_WIDTH-1:0] cap_code;
   logic                    flag;
   logic                    cap_flag;
   logic                    valid;
   int                      errors = 0;
   int                      num_checks = 0;
   always #25 clock = ~clock;
   adc_output_code_formatter adc_output_code_formatter_inst (.clock(clock), .rst_b(rst_b),
      .clk_en(enable), .sample_strobe(strobe), .comparator_code(code),
      .above_top_reference_sense(above), .top_bit_flip_select(top),
      .lower_bits_flip_select(lower), .conversion_result(result), .over_range(flag),
      .result_valid(valid));
   capture_model capture_model_inst (.clock(clock), .rst_b(rst_b), .result_valid(valid),
      .conversion_result(result), .over_range(flag), .captured_code(cap_code),
      .captured_flag(cap_flag));
   task check(input logic [15:0] seen, input logic [15:0] expected);
      num_checks++;
      if (seen !== expected) begin
         errors++;
         $display("ERROR at %0t seen %h expected %h", $time, seen, expected);
      end
   endtask : check
   task give_verdict();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : give_verdict
   // One conversion; the word settles three clocks before the strobe rises.
   task convert(input logic [9:0] step, input logic over);
      code <= step;
      above <= over;
      repeat (3) @(posedge clock);
      strobe <= 1'b1;
      for (int i = 0; i < 8 && valid !== 1'b1; i++) @(posedge clock);
      check(16'(valid), 16'h0001);
      @(posedge clock);
      check(16'(valid), 16'h0000);
      strobe <= 1'b0;
      repeat (3) @(posedge clock);
   endtask : convert
   // Selects change only while idle, then settle before any conversion.
   task set_mode(input int m);
      top <= m[1];
      lower <= m[0];
      repeat (4) @(posedge clock);
   endtask : set_mode
   task check_codings();
      static logic [9:0] steps [6] = '{10'h000, 10'h001, 10'h1FF, 10'h200, 10'h3FE, 10'h3FF};
      for (int m = 0; m < 4; m++) begin
         set_mode(m);
         foreach (steps[i]) begin
            convert(steps[i], 1'b0);
            check(16'(cap_code), 16'(steps[i] ^ {m[1], {9{m[0]}}}));
            check(16'(cap_flag), 16'h0000);
         end
      end
   endtask : check_codings
   task check_over_range();
      for (int m = 0; m < 4; m++) begin
         set_mode(m);
         convert(10'h155, 1'b1);
         check(16'(cap_code), 16'(FULL_SCALE_CODE ^ {m[1], {9{m[0]}}}));
         check(16'(cap_flag), 16'h0001);
      end
   endtask : check_over_range
   // A strobe raised while the block is disabled must wait until it runs again.
   task check_freeze();
      set_mode(0);
      convert(10'h0AA, 1'b0);
      enable <= 1'b0;
      code <= 10'h155;
      repeat (3) @(posedge clock);
      strobe <= 1'b1;
      repeat (8) @(posedge clock);
      check(16'(valid), 16'h0000);
      check(16'(result), 16'h00AA);
      enable <= 1'b1;
      for (int i = 0; i < 8 && valid !== 1'b1; i++) @(posedge clock);
      check(16'(valid), 16'h0001);
      @(posedge clock);
      check(16'(cap_code), 16'h0155);
      strobe <= 1'b0;
      repeat (3) @(posedge clock);
   endtask : check_freeze
   initial begin
      #(4000 * 50);
      errors++;
      give_verdict();
   end
   initial begin
      repeat (8) @(posedge clock);
      check({4'h0, result, flag, valid}, 16'h0000);
      rst_b <= 1'b1;
      check_codings();
      check_over_range();
      check_freeze();
      give_verdict();
   end
endmodule : adc_output_code_formatter_test
`default_nettype wire
